// *** core/pmmd_pkg.sv ***
`default_nettype none
package pmmd_pkg;
	// ****************************************
	// program memory map
	// ****************************************
	localparam int unsigned PM_ADDR_W = 16;
	localparam int unsigned KB = 1024;
	localparam logic [15:0] OPT_BYTES_LO = 16'h0000;
	localparam logic [15:0] RESET_VEC_LO = 16'h0002;
	localparam logic [15:0] WDOG_VEC_LO = 16'h0004;
	localparam logic [15:0] ILL_TRAP_LO = 16'h0006;
	localparam logic [15:0] IRQ_VEC_LO = 16'h0008;
	localparam logic [15:0] IRQ_VEC_HI = 16'h0037;
	localparam logic [15:0] RSVD_VEC_LO = 16'h0038;
	localparam logic [15:0] OSC_TRAP_LO = 16'h003a;
	localparam logic [15:0] OSC_TRAP_HI = 16'h003d;
	localparam logic [15:0] CODE_LO = 16'h003e;
	localparam logic [7:0] UNIMPL_BYTE = 8'hff;
	// ****************************************
	// information area
	// ****************************************
	localparam logic [15:0] INFO_LO = 16'hfe00;
	localparam logic [15:0] INFO_HI = 16'hff7f;
	localparam int unsigned INFO_BYTES = 128;
	localparam logic [6:0] INFO_FACT_HI = 7'h3f;
	localparam logic [6:0] INFO_PART_LO = 7'h40;
	localparam logic [6:0] INFO_PART_HI = 7'h53;
	localparam logic [6:0] INFO_CAL_LO = 7'h60;
	localparam logic [6:0] INFO_CAL_HI = 7'h7f;
	localparam int unsigned INFO_SEL_BIT = 7;
	// ****************************************
	// register file map
	// ****************************************
	localparam int unsigned RF_ADDR_W = 12;
	localparam logic [11:0] RF_CTRL_LO = 12'hf00;
	localparam logic [7:0] RF_UNDEF_BYTE = 8'h00;

	typedef enum logic [2:0] {
		PMMD_OPT = 3'b000,
		PMMD_RESET_VEC = 3'b001,
		PMMD_WDOG_VEC = 3'b010,
		PMMD_ILL_TRAP = 3'b011,
		PMMD_IRQ_VEC = 3'b100,
		PMMD_RSVD_VEC = 3'b101,
		PMMD_OSC_TRAP = 3'b110,
		PMMD_CODE = 3'b111
	} pmmd_region_e;
endpackage
`default_nettype wire

// *** core/pmmd_info_rom.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmmd_info_rom
	import pmmd_pkg::*;
#(
	parameter logic [8*INFO_BYTES-1:0] INFO_IMAGE = {INFO_BYTES{8'hff}}
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [6:0] infoAddr,
	output logic [7:0] infoData
);
	// read-only: no write port exists at all
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			infoData <= 8'h00;
		end else begin
			infoData <= INFO_IMAGE[{infoAddr, 3'h0} +: 8];
		end
	end
endmodule // pmmd_info_rom
`default_nettype wire

// *** core/pmmd_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmmd_decoder
	import pmmd_pkg::*;
#(
	parameter int unsigned FLASH_KB = 8,
	parameter int unsigned RAM_BYTES = 1024,
	parameter logic [7:0] PERIPH_PRESENT = 8'hff,
	parameter logic [8*INFO_BYTES-1:0] INFO_IMAGE = {INFO_BYTES{8'hff}}
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] pageSel,
	input wire logic pmRdReq,
	input wire logic pmWrReq,
	input wire logic [15:0] pmAddr,
	output logic [7:0] pmRdData,
	output logic pmRdValid,
	output logic flashRdEn,
	output logic flashWrEn,
	output logic [15:0] flashAddr,
	input wire logic [7:0] flashRdData,
	output logic [2:0] pmRegion,
	input wire logic dmRdReq,
	input wire logic dmWrReq,
	output logic [7:0] dmRdData,
	input wire logic rfRdReq,
	input wire logic rfWrReq,
	input wire logic [11:0] rfAddr,
	output logic rfRamSel,
	output logic rfCtrlSel,
	output logic rfReserved,
	output logic rfWrEn
);
	// ****************************************
	// decode functions
	// ****************************************
	localparam logic [16:0] FLASH_TOP = 17'((FLASH_KB * KB) - 1);
	localparam logic [12:0] RAM_TOP = 13'(RAM_BYTES - 1);

	function automatic logic inFlash(input logic [15:0] a);
		return {1'b0, a} <= FLASH_TOP;
	endfunction

	function automatic logic inInfo(input logic [15:0] a, input logic [7:0] sel);
		return sel[INFO_SEL_BIT] && a >= INFO_LO && a <= INFO_HI;
	endfunction

	function automatic pmmd_region_e regionOf(input logic [15:0] a);
		if (a < RESET_VEC_LO) return PMMD_OPT;
		else if (a < WDOG_VEC_LO) return PMMD_RESET_VEC;
		else if (a < ILL_TRAP_LO) return PMMD_WDOG_VEC;
		else if (a < IRQ_VEC_LO) return PMMD_ILL_TRAP;
		else if (a <= IRQ_VEC_HI) return PMMD_IRQ_VEC;
		else if (a < OSC_TRAP_LO) return PMMD_RSVD_VEC;
		else if (a <= OSC_TRAP_HI) return PMMD_OSC_TRAP;
		else return PMMD_CODE;
	endfunction

	// ****************************************
	// register file decode functions
	// ****************************************
	function automatic logic inRam(input logic [11:0] a);
		return {1'b0, a} <= RAM_TOP;
	endfunction

	function automatic logic inCtrl(input logic [11:0] a);
		return a >= RF_CTRL_LO;
	endfunction

	// one presence bit per 32-byte control block
	function automatic logic periphFitted(input logic [11:0] a);
		return PERIPH_PRESENT[a[7:5]];
	endfunction

	// ****************************************
	// read answer source
	// ****************************************
	typedef enum logic [1:0] {
		PMMD_SRC_NONE = 2'b00,
		PMMD_SRC_FLASH = 2'b01,
		PMMD_SRC_INFO = 2'b10
	} pmmd_src_e;

	// ****************************************
	// program memory request side
	// ****************************************
	logic infoHit;
	logic flashHit;
	logic [7:0] infoData;
	logic pmRdPend_r;
	pmmd_src_e rdSrc_r;
	pmmd_src_e rdSrc_nxt;

	assign infoHit = inInfo(pmAddr, pageSel);
	assign flashHit = inFlash(pmAddr) && !infoHit;
	assign flashRdEn = pmRdReq && flashHit;
	// a write paired with a read is dropped, the read wins
	assign flashWrEn = pmWrReq && flashHit && !pmRdReq;
	assign flashAddr = pmAddr;
	assign pmRegion = regionOf(pmAddr);

	// overlay takes priority over the flash beneath it
	always_comb begin
		if (!pmRdReq) begin
			rdSrc_nxt = PMMD_SRC_NONE;
		end else if (infoHit) begin
			rdSrc_nxt = PMMD_SRC_INFO;
		end else if (flashHit) begin
			rdSrc_nxt = PMMD_SRC_FLASH;
		end else begin
			rdSrc_nxt = PMMD_SRC_NONE;
		end
	end

	// same one-cycle latency as the flash array
	pmmd_info_rom #(
		.INFO_IMAGE(INFO_IMAGE)
	) uInfo (
		.sys_clk(sys_clk),
		.rst(rst),
		.infoAddr(pmAddr[6:0]),
		.infoData(infoData)
	);

	// ****************************************
	// program memory answer side
	// ****************************************
	// exactly one answer per taken request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pmRdPend_r <= 1'b0;
		end else begin
			pmRdPend_r <= pmRdReq;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdSrc_r <= PMMD_SRC_NONE;
		end else begin
			rdSrc_r <= rdSrc_nxt;
		end
	end

	assign pmRdValid = pmRdPend_r;

	always_comb begin
		unique case (rdSrc_r)
			PMMD_SRC_INFO: begin
				pmRdData = infoData;
			end
			PMMD_SRC_FLASH: begin
				pmRdData = flashRdData;
			end
			PMMD_SRC_NONE: begin
				pmRdData = UNIMPL_BYTE;
			end
			// unused code: answer as unimplemented
			default: begin
				pmRdData = UNIMPL_BYTE;
			end
		endcase
	end

	// ****************************************
	// data memory: not implemented
	// ****************************************
	logic dmUnused;

	// requests are swallowed, no storage behind them
	assign dmUnused = dmRdReq | dmWrReq;
	assign dmRdData = RF_UNDEF_BYTE;

	// ****************************************
	// register file
	// ****************************************
	logic rfReq;
	logic ramHit;
	logic ctrlHit;
	logic periphOk;

	assign rfReq = rfRdReq || rfWrReq;
	assign ramHit = inRam(rfAddr);
	assign ctrlHit = inCtrl(rfAddr);
	assign periphOk = periphFitted(rfAddr);

	always_comb begin
		rfRamSel = 1'b0;
		rfCtrlSel = 1'b0;
		rfReserved = 1'b0;
		if (rfReq) begin
			if (ramHit) begin
				rfRamSel = 1'b1;
			end else if (ctrlHit && periphOk) begin
				rfCtrlSel = 1'b1;
			end else begin
				// gap above the RAM, or a block this variant lacks
				rfReserved = 1'b1;
			end
		end
	end

	// reserved locations never see a write strobe
	assign rfWrEn = rfWrReq && (rfRamSel || rfCtrlSel);
endmodule // pmmd_decoder
`default_nettype wire

// *** verif/pmmd_flash_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmmd_flash_model (
	input wire logic sys_clk,
	input wire logic flashRdEn,
	input wire logic [15:0] flashAddr,
	output logic [7:0] flashRdData
);
	// sync array; stale data inverted when idle
	always_ff @(posedge sys_clk)
		flashRdData <= flashRdEn ? flashAddr[7:0] ^ flashAddr[15:8]
			: ~flashRdData;
endmodule // pmmd_flash_model
`default_nettype wire

// *** verif/pmmd_decoder_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmmd_decoder_props
	import pmmd_pkg::*;
#(
	parameter int unsigned FLASH_KB = 8,
	parameter int unsigned RAM_BYTES = 1024
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] pageSel,
	input wire logic pmRdReq,
	input wire logic pmWrReq,
	input wire logic [15:0] pmAddr,
	input wire logic [7:0] pmRdData,
	input wire logic pmRdValid,
	input wire logic flashWrEn,
	input wire logic [2:0] pmRegion,
	input wire logic rfWrReq,
	input wire logic [11:0] rfAddr,
	input wire logic rfRamSel,
	input wire logic rfReserved,
	input wire logic rfWrEn
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic ovl = pageSel[7] && pmAddr >= INFO_LO && pmAddr <= INFO_HI;
	wire logic far = pmAddr >= FLASH_KB * KB;
	property p_ans; pmRdReq |=> pmRdValid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; pmRdValid |-> $past(pmRdReq); endproperty
	a_one: assert property (p_one) else $error("stray valid");
	property p_ffh;
		pmRdReq && far && !ovl |=> pmRdData == UNIMPL_BYTE;
	endproperty
	a_ffh: assert property (p_ffh) else $error("not ff");
	property p_wro; pmWrReq && far |-> !flashWrEn; endproperty
	a_wro: assert property (p_wro) else $error("write passed");
	property p_vec;
		pmAddr[15:1] == 15'h1 |-> pmRegion == PMMD_RESET_VEC;
	endproperty
	a_vec: assert property (p_vec) else $error("bad region");
	property p_ro; pmWrReq && ovl |-> !flashWrEn; endproperty
	a_ro: assert property (p_ro) else $error("overlay written");
	property p_ram;
		rfWrReq && rfAddr < RAM_BYTES |-> rfRamSel && rfWrEn;
	endproperty
	a_ram: assert property (p_ram) else $error("ram miss");
	property p_rsv; rfWrReq && rfAddr >= RAM_BYTES && rfAddr < RF_CTRL_LO
		|-> rfReserved && !rfWrEn; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved write");
endmodule // pmmd_decoder_props
bind pmmd_decoder pmmd_decoder_props #(.FLASH_KB(FLASH_KB),
	.RAM_BYTES(RAM_BYTES)) u_props (.sys_clk(sys_clk), .rst(rst),
	.pageSel(pageSel), .pmRdReq(pmRdReq), .pmWrReq(pmWrReq), .pmAddr(pmAddr),
	.pmRdData(pmRdData), .pmRdValid(pmRdValid), .flashWrEn(flashWrEn),
	.pmRegion(pmRegion), .rfWrReq(rfWrReq), .rfAddr(rfAddr),
	.rfRamSel(rfRamSel), .rfReserved(rfReserved), .rfWrEn(rfWrEn));
`default_nettype wire

// *** verif/pmmd_decoder_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmmd_decoder_bench import pmmd_pkg::*;;
	logic sys_clk, rst, pmRdReq, pmWrReq, dmRdReq, dmWrReq, rfRdReq, rfWrReq;
	logic pmRdValid, flashRdEn, flashWrEn, rfRamSel, rfCtrlSel, rfReserved;
	logic rfWrEn;
	logic [7:0] pageSel, pmRdData, flashRdData, dmRdData;
	logic [15:0] pmAddr, flashAddr;
	logic [11:0] rfAddr;
	logic [2:0] pmRegion;
	int badCount, testsRun;
	function automatic logic [8*INFO_BYTES-1:0] img();
		for (int i = 0; i < INFO_BYTES; i++) img[8*i+:8] = i[7:0];
	endfunction
	pmmd_decoder #(.FLASH_KB(2), .RAM_BYTES(512), .PERIPH_PRESENT(8'hfe),
		.INFO_IMAGE(img())) dut (.sys_clk(sys_clk), .rst(rst),
		.pageSel(pageSel), .pmRdReq(pmRdReq), .pmWrReq(pmWrReq),
		.pmAddr(pmAddr), .pmRdData(pmRdData), .pmRdValid(pmRdValid),
		.flashRdEn(flashRdEn), .flashWrEn(flashWrEn), .flashAddr(flashAddr),
		.flashRdData(flashRdData), .pmRegion(pmRegion), .dmRdReq(dmRdReq),
		.dmWrReq(dmWrReq), .dmRdData(dmRdData), .rfRdReq(rfRdReq),
		.rfWrReq(rfWrReq), .rfAddr(rfAddr), .rfRamSel(rfRamSel),
		.rfCtrlSel(rfCtrlSel), .rfReserved(rfReserved), .rfWrEn(rfWrEn));
	pmmd_flash_model u_flash (.sys_clk(sys_clk), .flashRdEn(flashRdEn),
		.flashAddr(flashAddr), .flashRdData(flashRdData));
	task closeOut();
		$display("checks %0d errors %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("Error %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	// k: 0 flash, 1 unimplemented, 2 info byte
	task rd(input logic [15:0] a, input logic [1:0] k, input logic [2:0] r);
		pmRdReq <= 1'b1;
		pmAddr <= a;
		#1 chk({flashRdEn, flashAddr}, {k == 2'd0, a});
		@(posedge sys_clk);
		pmRdReq <= 1'b0;
		#1 chk({pmRdValid, pmRegion}, {1'b1, r});
		chk(pmRdData, k == 0 ? a[7:0] ^ a[15:8] : k == 1 ? UNIMPL_BYTE
			: a[6:0]);
		@(posedge sys_clk);
	endtask
	task wr(input logic [15:0] a, input logic e);
		pmWrReq <= 1'b1;
		pmAddr <= a;
		#1 chk(flashWrEn, e);
		@(posedge sys_clk);
		pmWrReq <= 1'b0;
		@(posedge sys_clk);
	endtask
	task rf(input logic [11:0] a, input logic w, input logic [3:0] e);
		rfWrReq <= w;
		rfRdReq <= !w;
		rfAddr <= a;
		#1 chk({rfRamSel, rfCtrlSel, rfReserved, rfWrEn}, e);
		@(posedge sys_clk);
		rfWrReq <= 1'b0;
		rfRdReq <= 1'b0;
		@(posedge sys_clk);
	endtask
	task t_rst();
		pmRdReq <= 1'b1;
		pmAddr <= 16'h0100;
		@(posedge sys_clk);
		pmRdReq <= 1'b0;
		rst <= 1'b1;
		#1 chk({pmRdValid, pmRdData}, {1'b0, UNIMPL_BYTE});
		@(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1 chk({pmRdValid, pmRdData}, {1'b0, UNIMPL_BYTE});
		@(posedge sys_clk);
	endtask
	task t_map();
		logic [15:0] va [8] = '{16'h0, 16'h2, 16'h4, 16'h6, 16'h8, 16'h38,
			16'h3a, 16'h3e};
		for (int i = 0; i < 8; i++) rd(va[i] + 16'h1, 0, i[2:0]);
		rd(16'h07ff, 0, 7);
		rd(16'h0800, 1, 7);
		wr(16'h0900, 1'b0);
		wr(16'h0100, 1'b1);
	endtask
	task t_info();
		pageSel <= 8'h80;
		rd(16'hfe00, 2, 7);
		rd(16'hfe45, 2, 7);
		rd(16'hfe7f, 2, 7);
		wr(16'hfe10, 1'b0);
		rd(16'hfe10, 2, 7);
		pageSel <= 8'h7f;
		rd(16'hfe45, 1, 7);
	endtask
	task t_rf();
		rf(12'h1ff, 1'b1, 4'b1001);
		rf(12'h0ff, 1'b0, 4'b1000);
		rf(12'h200, 1'b1, 4'b0010);
		rf(12'heff, 1'b0, 4'b0010);
		rf(12'hf05, 1'b1, 4'b0010);
		rf(12'hf25, 1'b1, 4'b0101);
		rf(12'hf25, 1'b0, 4'b0100);
		dmRdReq <= 1'b1;
		dmWrReq <= 1'b1;
		#1 chk({dmRdData, flashWrEn}, 9'h0);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#100us;
		badCount++;
		closeOut();
	end
	initial begin
		{rst, pmRdReq, pmWrReq, dmRdReq, dmWrReq, rfRdReq, rfWrReq} = 7'h40;
		{pageSel, pmAddr, rfAddr} = 36'h0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_map();
		t_info();
		t_rst();
		t_rf();
		closeOut();
	end
endmodule // pmmd_decoder_bench
`default_nettype wire
